// ### src/pulse_divided_pwm_14bit.sv
// Top of the 14-bit pulse-divided PWM with its Wishbone register slave
//
// Notes on behaviour
// - Select 0: period 16384 clocks; 1: 32768
// - Select bit and reserved bits read as one
// - Control register resets to fe, fast period
// - Duty: six upper bits, eight lower bits
// - Upper write transfers value, synced update
// - Duty bytes are write-only, read all ones
// - Duty pair resets to c000
// - Each period holds 64 pulses
// - Period high time: duty plus 64 clocks, twice that when slow
// - Duty 3fc0 to 3fff keeps output high
// - High time spread over many pulses
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module pulse_divided_pwm_14bit
  import pwm14_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Waveform output
  output logic pwm_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam pwm_state_t ST_RST = '{
    ack: 1'b0,
    rdata: UNMAPPED_READ_VALUE,
    period_select_bit: CLOCK_CONTROL_RST[PERIOD_SELECT_POS],
    duty_lower_byte: DUTY_LOWER_RST,
    duty_xfer: {DUTY_UPPER_RST[DUTY_UPPER_W-1:0], DUTY_LOWER_RST},
    active: '{slow: CLOCK_CONTROL_RST[PERIOD_SELECT_POS], duty: '0},
    prescale: 1'b0,
    unit: '0,
    pulse: '0,
    pwm: 1'b0
  };

  pwm_state_t st_r;
  pwm_state_t st_nxt;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    logic hit;
    if (idx == IDX_CLOCK_CONTROL) begin
      hit = 1'b1;
    end else if (idx == IDX_DUTY_UPPER) begin
      hit = 1'b1;
    end else if (idx == IDX_DUTY_LOWER) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  logic [IDX_W-1:0] idx;
  logic bus_req;
  logic wr;
  logic wr_ctl;
  logic wr_upper;
  logic wr_lower;

  assign idx = adr_i[ADR_W-1:2];
  assign bus_req = cyc_i & stb_i;
  // Writes land on the edge where the master sees ack
  assign wr = bus_req & we_i & sel_i[0] & st_r.ack;
  assign wr_ctl = wr && (idx == IDX_CLOCK_CONTROL);
  assign wr_upper = wr && (idx == IDX_DUTY_UPPER);
  assign wr_lower = wr && (idx == IDX_DUTY_LOWER);

  // ----------------------------------------
  // Waveform timing
  // ----------------------------------------
  logic step;
  logic unit_wrap;
  logic period_end;
  logic slot_high;

  assign step = ~st_r.active.slow | st_r.prescale;
  assign unit_wrap = step && (st_r.unit == {UNIT_BITS{1'b1}});
  assign period_end = unit_wrap && (st_r.pulse == {PULSE_BITS{1'b1}});

  pulse_slot_level #(
    .PULSE_W(PULSE_BITS),
    .UNIT_W(UNIT_BITS)
  ) u_level (
    .duty(st_r.active.duty),
    .pulse(st_r.pulse),
    .unit(st_r.unit),
    .high(slot_high)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Bus answer one cycle after the request
    st_nxt.ack = bus_req & ~st_r.ack;
    if (bus_req && !we_i && is_mapped(idx)) begin
      st_nxt.rdata = WO_READ_VALUE;
    end else begin
      st_nxt.rdata = UNMAPPED_READ_VALUE;
    end
    // Register writes
    if (wr_ctl) begin
      st_nxt.period_select_bit = dat_i[PERIOD_SELECT_POS];
    end
    if (wr_lower) begin
      st_nxt.duty_lower_byte = dat_i[DUTY_LOWER_W-1:0];
    end
    if (wr_upper) begin
      st_nxt.duty_xfer = {dat_i[DUTY_UPPER_W-1:0], st_r.duty_lower_byte};
    end
    // Counters of units and pulses
    if (period_end) begin
      st_nxt.prescale = 1'b0;
    end else begin
      st_nxt.prescale = st_r.active.slow & ~st_r.prescale;
    end
    if (step) begin
      st_nxt.unit = st_r.unit + 1'b1;
    end
    if (unit_wrap) begin
      st_nxt.pulse = st_r.pulse + 1'b1;
    end
    // New data and period take effect at a period boundary
    if (period_end) begin
      st_nxt.active.slow = st_r.period_select_bit;
      st_nxt.active.duty = st_r.duty_xfer;
    end
    st_nxt.pwm = slot_high;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dat_o = {24'h000000, st_r.rdata};
  assign ack_o = st_r.ack;
  assign pwm_o = st_r.pwm;

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  logic [15:0] per_cnt_r;
  logic [15:0] hi_cnt_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= 16'h0000;
      hi_cnt_r <= 16'h0000;
    end else if (period_end) begin
      per_cnt_r <= 16'h0000;
      hi_cnt_r <= 16'h0000;
    end else begin
      per_cnt_r <= per_cnt_r + 16'h0001;
      hi_cnt_r <= hi_cnt_r + {15'h0000, slot_high};
    end
  end

  int expected_high;

  always_comb begin
    if (st_r.active.duty >= FULL_HIGH_MIN) begin
      expected_high = PERIOD_FAST_CLKS;
    end else begin
      expected_high = int'(st_r.active.duty) + DUTY_OFFSET;
    end
    if (st_r.active.slow) begin
      expected_high = expected_high * 2;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_upper_write;
    wr_upper;
  endsequence

  sequence s_lone_lower_write;
    wr_lower && !wr_upper;
  endsequence

  sequence s_held_reset;
    !rst_n ##1 !rst_n;
  endsequence

  property p_period_len;
    @(posedge clock) disable iff (!rst_n)
      period_end |-> (int'(per_cnt_r) + 1 ==
        (st_r.active.slow ? PERIOD_SLOW_CLKS : PERIOD_FAST_CLKS));
  endproperty
  a_period_len: assert property (p_period_len)
    else $error("conversion period length wrong");

  property p_ctl_read;
    @(posedge clock) disable iff (!rst_n)
      (ack_o && cyc_i && stb_i && !we_i && idx == IDX_CLOCK_CONTROL)
        |-> dat_o[7:0] == WO_READ_VALUE;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control register did not read as all ones");

  property p_select_cause;
    @(posedge clock) disable iff (!rst_n)
      $changed(st_r.period_select_bit) |-> $past(wr_ctl);
  endproperty
  a_select_cause: assert property (p_select_cause)
    else $error("period select changed without a control write");

  property p_upper_xfer;
    @(posedge clock) disable iff (!rst_n)
      s_upper_write |=> st_r.duty_xfer ==
        {$past(dat_i[5:0]), $past(st_r.duty_lower_byte)};
  endproperty
  a_upper_xfer: assert property (p_upper_xfer)
    else $error("upper write did not transfer the full duty value");

  property p_active_update;
    @(posedge clock) disable iff (!rst_n)
      $changed(st_r.active) |-> $past(period_end);
  endproperty
  a_active_update: assert property (p_active_update)
    else $error("waveform data changed off a period boundary");

  property p_duty_read;
    @(posedge clock) disable iff (!rst_n)
      (ack_o && cyc_i && stb_i && !we_i &&
        (idx == IDX_DUTY_UPPER || idx == IDX_DUTY_LOWER))
        |-> dat_o == 32'h000000ff;
  endproperty
  a_duty_read: assert property (p_duty_read)
    else $error("duty byte did not read as all ones");

  property p_pulse_step;
    @(posedge clock) disable iff (!rst_n)
      unit_wrap |=> st_r.pulse == $past(st_r.pulse) + 6'h01;
  endproperty
  a_pulse_step: assert property (p_pulse_step)
    else $error("pulse index did not advance at slot end");

  property p_high_total;
    @(posedge clock) disable iff (!rst_n)
      period_end |-> int'(hi_cnt_r) + int'(slot_high) == expected_high;
  endproperty
  a_high_total: assert property (p_high_total)
    else $error("period high time does not match duty plus offset");

  property p_full_high;
    @(posedge clock) disable iff (!rst_n)
      (st_r.active.duty >= FULL_HIGH_MIN) |-> slot_high ##1 pwm_o;
  endproperty
  a_full_high: assert property (p_full_high)
    else $error("output not continuously high for top duty values");

  property p_spread_low;
    @(posedge clock) disable iff (!rst_n)
      (st_r.active.duty[13:6] < 8'hfe &&
        {1'b0, st_r.unit} == {1'b0, st_r.active.duty[13:6]} + 9'h002)
        |-> !slot_high;
  endproperty
  a_spread_low: assert property (p_spread_low)
    else $error("pulse stayed high past its share of the period");

  property p_base_width;
    @(posedge clock) disable iff (!rst_n)
      (st_r.unit <= st_r.active.duty[13:6]) |-> slot_high;
  endproperty
  a_base_width: assert property (p_base_width)
    else $error("pulse shorter than its base width");

  property p_lower_held;
    @(posedge clock) disable iff (!rst_n)
      s_lone_lower_write |=> $stable(st_r.duty_xfer);
  endproperty
  a_lower_held: assert property (p_lower_held)
    else $error("lower byte write alone changed the duty value");

  property p_reset_select;
    @(posedge clock)
      s_held_reset |-> st_r.period_select_bit == CLOCK_CONTROL_RST[PERIOD_SELECT_POS]
        && st_r.active.slow == CLOCK_CONTROL_RST[PERIOD_SELECT_POS];
  endproperty
  a_reset_select: assert property (p_reset_select)
    else $error("period select not fast during reset");

  property p_reset_duty;
    @(posedge clock)
      s_held_reset |-> st_r.duty_xfer == {DUTY_UPPER_RST[DUTY_UPPER_W-1:0], DUTY_LOWER_RST}
        && st_r.active.duty == {DUTY_UPPER_RST[DUTY_UPPER_W-1:0], DUTY_LOWER_RST};
  endproperty
  a_reset_duty: assert property (p_reset_duty)
    else $error("duty value not cleared during reset");

  property p_ctl_write;
    @(posedge clock) disable iff (!rst_n)
      wr_ctl |=> st_r.period_select_bit == $past(dat_i[PERIOD_SELECT_POS]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write did not set the period select");

  property p_slow_step;
    @(posedge clock) disable iff (!rst_n)
      (st_r.active.slow && $past(st_r.active.slow)) |-> step != $past(step);
  endproperty
  a_slow_step: assert property (p_slow_step)
    else $error("slow period does not step every second clock");

  property p_period_restart;
    @(posedge clock) disable iff (!rst_n)
      period_end |=> st_r.unit == {UNIT_BITS{1'b0}}
        && st_r.pulse == {PULSE_BITS{1'b0}};
  endproperty
  a_period_restart: assert property (p_period_restart)
    else $error("new period did not start at pulse zero");

  property p_lower_store;
    @(posedge clock) disable iff (!rst_n)
      wr_lower |=> st_r.duty_lower_byte == $past(dat_i[DUTY_LOWER_W-1:0]);
  endproperty
  a_lower_store: assert property (p_lower_store)
    else $error("lower byte write was not stored");

endmodule // pulse_divided_pwm_14bit

// ### src/pwm14_pkg.sv
// Package: register map, reset values, timing counts and carriers of the 14-bit PWM
package pwm14_pkg;

  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam int ADR_W = 18;
  localparam int IDX_W = 16;
  localparam logic [IDX_W-1:0] IDX_CLOCK_CONTROL = 16'hffcc;
  localparam logic [IDX_W-1:0] IDX_DUTY_UPPER = 16'hffcd;
  localparam logic [IDX_W-1:0] IDX_DUTY_LOWER = 16'hffce;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int PERIOD_SELECT_POS = 0;
  localparam int DUTY_UPPER_W = 6;
  localparam int DUTY_LOWER_W = 8;
  localparam int DUTY_W = DUTY_UPPER_W + DUTY_LOWER_W;
  localparam logic [7:0] CLOCK_CONTROL_RST = 8'hfe;
  localparam logic [7:0] DUTY_UPPER_RST = 8'hc0;
  localparam logic [7:0] DUTY_LOWER_RST = 8'h00;
  localparam logic [7:0] WO_READ_VALUE = 8'hff;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ----------------------------------------
  // Waveform shape and cycle counts
  // ----------------------------------------
  localparam int PULSE_BITS = 6;
  localparam int UNIT_BITS = 8;
  localparam int DUTY_OFFSET = 64;
  localparam int PERIOD_FAST_CLKS = 16384;
  localparam int PERIOD_SLOW_CLKS = 32768;
  localparam logic [DUTY_W-1:0] FULL_HIGH_MIN = 14'h3fc0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic slow;
    logic [DUTY_W-1:0] duty;
  } pwm_cfg_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic period_select_bit;
    logic [DUTY_LOWER_W-1:0] duty_lower_byte;
    logic [DUTY_W-1:0] duty_xfer;
    pwm_cfg_t active;
    logic prescale;
    logic [UNIT_BITS-1:0] unit;
    logic [PULSE_BITS-1:0] pulse;
    logic pwm;
  } pwm_state_t;

endpackage

// ### src/pulse_slot_level.sv
// Level of the PWM output for one unit of one pulse slot
`timescale 1ns/1ps
module pulse_slot_level
  import pwm14_pkg::*;
#(
  parameter int PULSE_W = 6,
  parameter int UNIT_W = 8
) (
  // Active duty and slot position
  input wire logic [PULSE_W+UNIT_W-1:0] duty,
  input wire logic [PULSE_W-1:0] pulse,
  input wire logic [UNIT_W-1:0] unit,
  // Result
  output logic high
);

  generate
    if (PULSE_W < 1 || UNIT_W < 1) begin : g_bad
      $error("pulse_slot_level: widths must be positive");
    end
  endgenerate

  // ----------------------------------------
  // Bit-reversed pulse index spreads extra units
  // ----------------------------------------
  logic [PULSE_W-1:0] pulse_rev;
  genvar gi;
  generate
    for (gi = 0; gi < PULSE_W; gi++) begin : g_rev
      assign pulse_rev[gi] = pulse[PULSE_W-1-gi];
    end
  endgenerate

  logic extra;
  logic [UNIT_W:0] width;

  always_comb begin
    extra = pulse_rev < duty[PULSE_W-1:0];
    width = {1'b0, duty[PULSE_W+UNIT_W-1:PULSE_W]} + {{UNIT_W{1'b0}}, 1'b1}
      + {{UNIT_W{1'b0}}, extra};
    high = {1'b0, unit} < width;
  end

endmodule // pulse_slot_level

// ### verif/lowpass_filter_model.sv
// Far-side model: filter that integrates the waveform over a measuring window
`timescale 1ns/1ps
module lowpass_filter_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Waveform and window control
  input wire logic pwm,
  input wire logic start,
  input wire logic [16:0] len,
  // Window result
  output logic done,
  output logic [16:0] high,
  output logic [7:0] rises,
  output logic [15:0] minw,
  output logic [15:0] maxw
);
  logic [16:0] left;
  logic [15:0] run;
  logic prev;
  logic live;

  // Partial pulse at the window start is left out of the width figures
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left <= 17'h0;
      done <= 1'b0;
      prev <= 1'b0;
      live <= 1'b0;
    end else begin
      done <= (left == 17'h1);
      prev <= pwm;
      if (start) begin
        left <= len;
        high <= 17'h0;
        rises <= 8'h0;
        minw <= 16'hffff;
        maxw <= 16'h0;
        live <= 1'b0;
      end else if (left != 17'h0) begin
        left <= left - 17'h1;
        high <= high + 17'(pwm);
        if (pwm && !prev) begin
          rises <= rises + 8'h1;
          live <= 1'b1;
          run <= 16'h1;
        end else if (pwm) begin
          run <= run + 16'h1;
        end else if (prev && live) begin
          if (run < minw) minw <= run;
          if (run > maxw) maxw <= run;
        end
      end
    end
  end
endmodule // lowpass_filter_model

// ### verif/pulse_divided_pwm_14bit_tb.sv
// Self-checking testbench of the 14-bit pulse-divided PWM
`timescale 1ns/1ps
module pulse_divided_pwm_14bit_tb import pwm14_pkg::*;;
  typedef struct packed {
    logic [16:0] high;
    logic [7:0] rises;
    logic [15:0] minw;
    logic [15:0] maxw;
  } wave_t;
  logic clock, rst_n, cyc, stb, we, ack_o, pwm_o, start, done;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, seed;
  logic [16:0] len, high;
  logic [7:0] rises;
  logic [15:0] minw, maxw;
  logic [13:0] d;
  int fail_count, n_compared;
  int clk_cnt, n_wait;
  logic [7:0] exp_rd[$];
  wave_t exp_wave[$];

  pulse_divided_pwm_14bit pulse_divided_pwm_14bit_inst (.clock(clock), .rst_n(rst_n),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o));
  lowpass_filter_model lowpass_filter_model_inst (.clock(clock), .rst_n(rst_n), .pwm(pwm_o),
    .start(start), .len(len), .done(done), .high(high), .rises(rises), .minw(minw),
    .maxw(maxw));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic check_rd(input logic [7:0] e, input logic [31:0] s);
    cmp("read data", {24'h0, e}, s);
  endtask

  task automatic check_wave(input wave_t e);
    cmp("high clocks", 32'(e.high), 32'(high));
    cmp("pulse count", 32'(e.rises), 32'(rises));
    if (e.rises != 8'h0) begin
      cmp("min width", 32'(e.minw), 32'(minw));
      cmp("max width", 32'(e.maxw), 32'(maxw));
    end
  endtask

  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] v);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dat <= {24'h0, v};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    exp_rd.push_back(e);
    wb(1'b0, idx, 8'h0);
  endtask

  task automatic measure(input logic [13:0] v, input logic s);
    wave_t e;
    logic [16:0] u, p;
    int n;
    u = s ? 17'd2 : 17'd1;
    p = s ? 17'd32768 : 17'd16384;
    e.high = (v >= FULL_HIGH_MIN) ? p : (17'(v) + 17'd64) * u;
    e.rises = (v >= FULL_HIGH_MIN) ? 8'd0 : 8'd64;
    e.minw = 16'((17'(v[13:6]) + 17'd1) * u);
    e.maxw = e.minw + ((v[5:0] != 6'h0) ? 16'(u) : 16'h0);
    exp_wave.push_back(e);
    @(posedge clock);
    len <= p;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    if (n >= 40000) begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clock) begin
    if (ack_o === 1'b1 && cyc && !we) check_rd(exp_rd.pop_front(), dat_o);
    if (done === 1'b1) check_wave(exp_wave.pop_front());
  end

  // Clocks since reset release, to place a window on a period boundary
  always @(posedge clock) clk_cnt <= rst_n ? clk_cnt + 1 : 0;

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, start} = 4'h0;
    adr = '0;
    sel = 4'h0;
    dat = 32'h0;
    len = 17'h0;
    fail_count = 0;
    n_compared = 0;
    seed = 32'heeb7c916;
    do_reset();
    rd(IDX_CLOCK_CONTROL, WO_READ_VALUE);
    rd(IDX_DUTY_UPPER, WO_READ_VALUE);
    rd(IDX_DUTY_LOWER, WO_READ_VALUE);
    rd(16'hffcf, UNMAPPED_READ_VALUE);
    measure(14'h0, 1'b0);
    $display("test reset_state done");
    do_reset();
    seed = lfsr_next(seed);
    d = seed[13:0] & 14'h3f7f;
    wb(1'b1, IDX_DUTY_LOWER, d[7:0]);
    wb(1'b1, IDX_DUTY_UPPER, {2'b11, d[13:8]});
    seed = lfsr_next(seed);
    wb(1'b1, IDX_DUTY_LOWER, seed[7:0]);
    wb(1'b1, IDX_CLOCK_CONTROL, 8'h00);
    rd(IDX_CLOCK_CONTROL, WO_READ_VALUE);
    // Window must cover whole pulses, else a lone wide pulse is cut
    n_wait = 0;
    while (clk_cnt != PERIOD_FAST_CLKS - 2 && n_wait < 20000) begin
      @(posedge clock);
      n_wait++;
    end
    if (n_wait >= 20000) begin
      fail_count++;
      complete_run();
    end
    measure(d, 1'b0);
    $display("test random_duty done");
    do_reset();
    wb(1'b1, IDX_CLOCK_CONTROL, 8'h01);
    wb(1'b1, IDX_DUTY_LOWER, 8'hff);
    wb(1'b1, IDX_DUTY_UPPER, 8'h3f);
    repeat (16384) @(posedge clock);
    measure(14'h3fff, 1'b1);
    $display("test slow_full_high done");
    complete_run();
  end
endmodule // pulse_divided_pwm_14bit_tb
